// [rtl/tpf_table_access.sv]
`timescale 1ns/1ps
module tpf_table_access #(
    parameter int LONG_WRITE_CYCLES = tpf_pkg::LONG_WRITE_CYC
) (
    // Clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        ARST_N,
    // Register port
    input  wire logic [3:0]  REG_ADDR,
    input  wire logic [7:0]  REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output logic      [7:0]  REG_RDATA,
    // Memory array side
    output logic      [21:0] MEM_RD_ADDR,
    input  wire logic [15:0] MEM_RD_WORD,
    input  wire logic [15:0] CFG_RD_WORD,
    output logic             MEM_PROG,
    output logic             MEM_ERASE,
    output logic      [21:0] MEM_BLOCK_ADDR,
    output logic      [63:0] MEM_PROG_DATA,
    // Core stall
    output logic             CORE_STALL
);
    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_LONG} tpf_state_e;

    localparam int TW = $clog2(LONG_WRITE_CYCLES + 1);

    ////////////////////////////////////////////////////////////////////////////
    // State

    tpf_state_e        state_q, state_d;
    logic [21:0]       ptr_q, ptr_d;
    logic [7:0]        latch_q, latch_d;
    logic [7:0]        hold_q [tpf_pkg::HOLD_N];
    logic [7:0]        hold_d [tpf_pkg::HOLD_N];
    logic              prog_sel_q = 1'b0;
    logic              prog_sel_d;
    logic              cfg_sel_q = 1'b0;
    logic              cfg_sel_d;
    logic              erase_sel_q, erase_sel_d;
    logic              permit_q, permit_d;
    logic              start_q, start_d;
    logic              abort_q, abort_d;
    logic [1:0]        key_q, key_d;
    logic [TW-1:0]     timer_q, timer_d;
    logic              rd_byte_q, rd_byte_d;
    logic [7:0]        rdata_q, rdata_d;
    logic [21:0]       blk_q, blk_d;
    logic              prog_q, prog_d;
    logic              erase_q, erase_d;
    logic [21:0]       rdaddr_q, rdaddr_d;
    logic              was_long_q;
    logic              abort_keep_q = 1'b0;

    logic [21:0]       acc_addr;
    logic [21:0]       upd_ptr;
    logic [7:0]        ctl_value;
    logic [15:0]       sel_word;

    tpf_ptr_update u_ptr (
        .ptr         (ptr_q),
        .mode        (REG_WDATA[1:0]),
        .access_addr (acc_addr),
        .next_ptr    (upd_ptr)
    );

    // Top pointer bit swaps in the ID/config space
    assign sel_word = rdaddr_q[tpf_pkg::PTR_SPACE] ? CFG_RD_WORD : MEM_RD_WORD;

    always_comb begin
        ctl_value = tpf_pkg::CTL_RESET;
        ctl_value[tpf_pkg::CTL_PROG_SEL]  = prog_sel_q;
        ctl_value[tpf_pkg::CTL_CFG_SEL]   = cfg_sel_q;
        ctl_value[tpf_pkg::CTL_ROW_ERASE] = erase_sel_q;
        ctl_value[tpf_pkg::CTL_ABORT]     = abort_q;
        ctl_value[tpf_pkg::CTL_PERMIT]    = permit_q;
        ctl_value[tpf_pkg::CTL_START]     = start_q;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        state_d     = state_q;
        ptr_d       = ptr_q;
        latch_d     = latch_q;
        hold_d      = hold_q;
        prog_sel_d  = prog_sel_q;
        cfg_sel_d   = cfg_sel_q;
        erase_sel_d = erase_sel_q;
        permit_d    = permit_q;
        start_d     = start_q;
        abort_d     = abort_q;
        key_d       = key_q;
        timer_d     = timer_q;
        rd_byte_d   = rd_byte_q;
        rdata_d     = 8'h00;
        blk_d       = blk_q;
        prog_d      = 1'b0;
        erase_d     = 1'b0;
        rdaddr_d    = rdaddr_q;

        // Any access other than the key sequence breaks it; a control write breaks it only while idle
        if ((REG_WR || REG_RD) && !(REG_WR && REG_ADDR == tpf_pkg::ADDR_KEY)) begin
            if (!(REG_WR && REG_ADDR == tpf_pkg::ADDR_CONTROL)) begin
                key_d = 2'h0;
            end
        end

        if (REG_RD) begin
            case (REG_ADDR)
                tpf_pkg::ADDR_PTR_LOW:   rdata_d = ptr_q[7:0];
                tpf_pkg::ADDR_PTR_HIGH:  rdata_d = ptr_q[15:8];
                tpf_pkg::ADDR_PTR_UPPER: rdata_d = {2'h0, ptr_q[21:16]};
                tpf_pkg::ADDR_LATCH:     rdata_d = latch_q;
                tpf_pkg::ADDR_CONTROL:   rdata_d = ctl_value;
                tpf_pkg::ADDR_STATUS:    rdata_d = {7'h00, state_q != ST_IDLE};
                default:                 rdata_d = 8'h00;
            endcase
        end

        if (REG_WR && state_q == ST_IDLE) begin
            case (REG_ADDR)
                tpf_pkg::ADDR_PTR_LOW:   ptr_d[7:0]   = REG_WDATA;
                tpf_pkg::ADDR_PTR_HIGH:  ptr_d[15:8]  = REG_WDATA;
                tpf_pkg::ADDR_PTR_UPPER: ptr_d[21:16] = REG_WDATA[5:0];
                tpf_pkg::ADDR_LATCH:     latch_d      = REG_WDATA;
                tpf_pkg::ADDR_KEY: begin
                    if (key_q == 2'h0 && REG_WDATA == tpf_pkg::KEY_FIRST) begin
                        key_d = 2'h1;
                    end else if (key_q == 2'h1 && REG_WDATA == tpf_pkg::KEY_SECOND) begin
                        key_d = 2'h2;
                    end else begin
                        key_d = 2'h0;
                    end
                end
                tpf_pkg::ADDR_CONTROL: begin
                    prog_sel_d  = REG_WDATA[tpf_pkg::CTL_PROG_SEL];
                    cfg_sel_d   = REG_WDATA[tpf_pkg::CTL_CFG_SEL];
                    erase_sel_d = REG_WDATA[tpf_pkg::CTL_ROW_ERASE];
                    permit_d    = REG_WDATA[tpf_pkg::CTL_PERMIT];
                    // Abort flag is software clearable only
                    abort_d     = abort_q & REG_WDATA[tpf_pkg::CTL_ABORT];
                    key_d       = 2'h0;
                    if (REG_WDATA[tpf_pkg::CTL_START] && key_q == 2'h2
                        && REG_WDATA[tpf_pkg::CTL_PERMIT]
                        && REG_WDATA[tpf_pkg::CTL_PROG_SEL]
                        && !REG_WDATA[tpf_pkg::CTL_CFG_SEL]) begin
                        start_d = 1'b1;
                        state_d = ST_LONG;
                        timer_d = TW'(LONG_WRITE_CYCLES);
                        if (REG_WDATA[tpf_pkg::CTL_ROW_ERASE]) begin
                            blk_d   = {ptr_q[21:6], 6'h00};
                            erase_d = 1'b1;
                        end else begin
                            blk_d = {ptr_q[21:3], 3'h0};
                            prog_d = 1'b1;
                        end
                    end
                end
                tpf_pkg::ADDR_TABLE_OP: begin
                    ptr_d = upd_ptr;
                    if (REG_WDATA[tpf_pkg::OP_WRITE_BIT]) begin
                        hold_d[acc_addr[2:0]] = latch_q;
                    end else begin
                        rdaddr_d  = acc_addr;
                        rd_byte_d = acc_addr[0];
                        state_d   = ST_READ;
                    end
                end
                default: begin
                end
            endcase
        end

        case (state_q)
            ST_IDLE: begin
            end
            ST_READ: begin
                // Single byte per table read
                latch_d = rd_byte_q ? sel_word[15:8] : sel_word[7:0];
                state_d = ST_IDLE;
            end
            ST_LONG: begin
                if (timer_q <= TW'(1)) begin
                    state_d     = ST_IDLE;
                    start_d     = 1'b0;
                    erase_sel_d = 1'b0;
                end else begin
                    timer_d = timer_q - TW'(1);
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase

        // Busy before the reset, idle since: the long write was cut short.
        // Placed last so the set wins over a software clear in the same cycle
        if (abort_keep_q && !was_long_q) begin
            abort_d = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    // Abort recorded on the first edge after a reset that hit a long write
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            was_long_q <= 1'b0;
        end else begin
            was_long_q <= (state_q == ST_LONG);
        end
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_q     <= ST_IDLE;
            ptr_q       <= 22'h000000;
            latch_q     <= 8'h00;
            for (int i = 0; i < tpf_pkg::HOLD_N; i++) begin
                hold_q[i] <= 8'hff;
            end
            erase_sel_q <= 1'b0;
            permit_q    <= 1'b0;
            start_q     <= 1'b0;
            abort_q     <= 1'b0;
            key_q       <= 2'h0;
            timer_q     <= '0;
            rd_byte_q   <= 1'b0;
            rdata_q     <= 8'h00;
            blk_q       <= 22'h000000;
            prog_q      <= 1'b0;
            erase_q     <= 1'b0;
            rdaddr_q    <= 22'h000000;
        end else begin
            state_q     <= state_d;
            ptr_q       <= ptr_d;
            latch_q     <= latch_d;
            hold_q      <= hold_d;
            erase_sel_q <= erase_sel_d;
            permit_q    <= permit_d;
            start_q     <= start_d;
            abort_q     <= abort_d;
            key_q       <= key_d;
            timer_q     <= timer_d;
            rd_byte_q   <= rd_byte_d;
            rdata_q     <= rdata_d;
            blk_q       <= blk_d;
            prog_q      <= prog_d;
            erase_q     <= erase_d;
            rdaddr_q    <= rdaddr_d;
        end
    end

    // Space selects and the busy record ride through the async reset like a
    // power-kept store; reset only freezes them, power-up clears them
    always_ff @(posedge SYS_CLK) begin
        if (ARST_N) begin
            prog_sel_q   <= prog_sel_d;
            cfg_sel_q    <= cfg_sel_d;
            abort_keep_q <= (state_q == ST_LONG);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign REG_RDATA      = rdata_q;
    assign MEM_RD_ADDR    = rdaddr_q;
    assign MEM_PROG       = prog_q;
    assign MEM_ERASE      = erase_q;
    assign MEM_BLOCK_ADDR = blk_q;
    assign CORE_STALL     = start_q;

    generate
        for (genvar g = 0; g < tpf_pkg::HOLD_N; g++) begin : g_hold
            assign MEM_PROG_DATA[g*8 +: 8] = hold_q[g];
        end
    endgenerate
endmodule

// [inc/tpf_pkg.sv]
package tpf_pkg;
    // Register indices on the plain register port
    localparam logic [3:0] ADDR_PTR_LOW   = 4'h0;
    localparam logic [3:0] ADDR_PTR_HIGH  = 4'h1;
    localparam logic [3:0] ADDR_PTR_UPPER = 4'h2;
    localparam logic [3:0] ADDR_LATCH     = 4'h3;
    localparam logic [3:0] ADDR_CONTROL   = 4'h4;
    localparam logic [3:0] ADDR_KEY       = 4'h5;
    localparam logic [3:0] ADDR_TABLE_OP  = 4'h6;
    localparam logic [3:0] ADDR_STATUS    = 4'h7;

    // Control register field positions
    localparam int CTL_PROG_SEL   = 7;
    localparam int CTL_CFG_SEL    = 6;
    localparam int CTL_ROW_ERASE  = 4;
    localparam int CTL_ABORT      = 3;
    localparam int CTL_PERMIT     = 2;
    localparam int CTL_START      = 1;
    localparam logic [7:0] CTL_RESET = 8'h00;

    // Table op register: bit 2 = write, bits 1:0 = pointer mode
    localparam int OP_WRITE_BIT = 2;
    localparam logic [1:0] MODE_KEEP     = 2'h0;
    localparam logic [1:0] MODE_POST_INC = 2'h1;
    localparam logic [1:0] MODE_POST_DEC = 2'h2;
    localparam logic [1:0] MODE_PRE_INC  = 2'h3;

    localparam logic [7:0] KEY_FIRST  = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;

    localparam int PTR_W      = 22;
    localparam int HOLD_N     = 8;
    localparam int PTR_SPACE  = 21;

    // Long write timing
    localparam int CLK_MHZ         = 100;
    localparam int LONG_WRITE_US   = 2000;
    localparam int LONG_WRITE_CYC  = LONG_WRITE_US * CLK_MHZ;
endpackage

// [rtl/tpf_ptr_update.sv]
`timescale 1ns/1ps
module tpf_ptr_update (
    // Pointer in and mode
    input  wire logic [21:0] ptr,
    input  wire logic [1:0]  mode,
    // Address used for access and pointer afterwards
    output logic      [21:0] access_addr,
    output logic      [21:0] next_ptr
);
    logic [20:0] inc_low;
    logic [20:0] dec_low;

    // Carry and borrow stay inside the low space
    assign inc_low = ptr[20:0] + 21'h1;
    assign dec_low = ptr[20:0] - 21'h1;

    always_comb begin
        access_addr = ptr;
        next_ptr    = ptr;
        case (mode)
            tpf_pkg::MODE_KEEP: begin
                next_ptr = ptr;
            end
            tpf_pkg::MODE_POST_INC: begin
                next_ptr = {ptr[21], inc_low};
            end
            tpf_pkg::MODE_POST_DEC: begin
                next_ptr = {ptr[21], dec_low};
            end
            tpf_pkg::MODE_PRE_INC: begin
                access_addr = {ptr[21], inc_low};
                next_ptr    = {ptr[21], inc_low};
            end
            default: begin
                next_ptr = ptr;
            end
        endcase
    end
endmodule

// [test/tpf_mem_model.sv]
`timescale 1ns/1ps
module tpf_mem_model (
    // Byte address of the table access
    input  wire logic [21:0] rd_addr,
    // Words of program and identification space
    output logic      [15:0] prog_word,
    output logic      [15:0] cfg_word
);
    // Keyed on word index only, so byte selection stays the unit's job
    assign prog_word = {rd_addr[8:1] ^ 8'h3c, rd_addr[16:9]};
    assign cfg_word  = {rd_addr[8:1] ^ 8'hc5, ~rd_addr[8:1]};
endmodule

// [test/tpf_table_access_sva.sv]
`timescale 1ns/1ps
module tpf_table_access_sva #(
    parameter int LONG_WRITE_CYCLES = 20
) (
    // Clock and reset
    input wire logic        SYS_CLK,
    input wire logic        ARST_N,
    // Register port
    input wire logic [3:0]  REG_ADDR,
    input wire logic [7:0]  REG_WDATA,
    input wire logic        REG_WR,
    // Array side and stall
    input wire logic        MEM_PROG,
    input wire logic        MEM_ERASE,
    input wire logic [21:0] MEM_BLOCK_ADDR,
    input wire logic        CORE_STALL
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!ARST_N);
    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    logic        ctl_wr;
    logic        key1;
    logic        key2;
    logic        go;
    logic        perm;
    logic        ers;
    ////////////////////////////////////////////////////////////////////////////////
    assign ctl_wr = REG_WR && REG_ADDR == tpf_pkg::ADDR_CONTROL;
    assign key1   = REG_WR && REG_ADDR == tpf_pkg::ADDR_KEY && REG_WDATA == 8'h55;
    assign key2   = REG_WR && REG_ADDR == tpf_pkg::ADDR_KEY && REG_WDATA == 8'haa;
    assign go     = ctl_wr && REG_WDATA[tpf_pkg::CTL_START];
    assign perm   = go && REG_WDATA[7] && !REG_WDATA[6] && REG_WDATA[2];
    assign ers    = go && REG_WDATA[tpf_pkg::CTL_ROW_ERASE];
    // Stall length counter, cleared whenever the core runs
    always_comb begin
        cnt_d = CORE_STALL ? cnt_q + 32'h1 : 32'h0;
    end
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cnt_q <= 32'h0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    property p_key_order;
        $rose(CORE_STALL) |-> $past(go) && $past(key2, 2) && $past(key1, 3);
    endproperty
    a_key_order: assert property (p_key_order) else $error("stall without key order");
    property p_key_starts;
        perm && $past(key2) && $past(key1, 2) && !CORE_STALL |=> CORE_STALL;
    endproperty
    a_key_starts: assert property (p_key_starts) else $error("keyed start ignored");
    property p_permit;
        $rose(CORE_STALL) |-> $past(perm);
    endproperty
    a_permit: assert property (p_permit) else $error("start without permit bits");
    property p_erase_row;
        MEM_ERASE |-> MEM_BLOCK_ADDR[5:0] == 6'h00 && $past(ers) && $rose(CORE_STALL);
    endproperty
    a_erase_row: assert property (p_erase_row) else $error("erase row wrong");
    property p_erase_once;
        MEM_ERASE |=> !MEM_ERASE [*8];
    endproperty
    a_erase_once: assert property (p_erase_once) else $error("erase repeated");
    property p_prog_blk;
        MEM_PROG |-> MEM_BLOCK_ADDR[2:0] == 3'h0 && !MEM_ERASE && $rose(CORE_STALL);
    endproperty
    a_prog_blk: assert property (p_prog_blk) else $error("program block wrong");
    property p_stall_len;
        $fell(CORE_STALL) |-> cnt_q == LONG_WRITE_CYCLES;
    endproperty
    a_stall_len: assert property (p_stall_len) else $error("stall length wrong");
    property p_busy_hold;
        CORE_STALL && ctl_wr && cnt_q < LONG_WRITE_CYCLES - 1 |=> CORE_STALL;
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("start cleared by write");
    c_erase: cover property (MEM_ERASE);
    c_prog: cover property (MEM_PROG);
    c_done: cover property ($fell(CORE_STALL));
endmodule
bind tpf_table_access tpf_table_access_sva #(.LONG_WRITE_CYCLES(LONG_WRITE_CYCLES)) u_sva (
    .SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .MEM_PROG(MEM_PROG), .MEM_ERASE(MEM_ERASE),
    .MEM_BLOCK_ADDR(MEM_BLOCK_ADDR), .CORE_STALL(CORE_STALL)
);

// [test/table_pointer_flash_access_test.sv]
`timescale 1ns/1ps
module table_pointer_flash_access_test;
    localparam int LWC = 20;
    localparam logic [21:0] BND [4] = '{22'h200001, 22'h3fffff, 22'h200000, 22'h1fffff};
    logic clk, arst_n, wr_s, rd_s, rd_flag, prog, ers, stall;
    logic [3:0]  addr;
    logic [7:0]  wdata, rdata, b;
    logic [21:0] rd_addr, blk, p, np, acc;
    logic [15:0] pw, cw, re;
    logic [63:0] hold, pdata;
    logic [87:0] ee;
    logic [20:0] d;
    logic [15:0] rd_q[$];
    logic [87:0] ev_q[$];
    int err_total, num_checks;

    tpf_table_access #(.LONG_WRITE_CYCLES(LWC)) dut (.SYS_CLK(clk), .ARST_N(arst_n),
        .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr_s), .REG_RD(rd_s), .REG_RDATA(rdata),
        .MEM_RD_ADDR(rd_addr), .MEM_RD_WORD(pw), .CFG_RD_WORD(cw), .MEM_PROG(prog),
        .MEM_ERASE(ers), .MEM_BLOCK_ADDR(blk), .MEM_PROG_DATA(pdata), .CORE_STALL(stall));
    tpf_mem_model u_mem (.rd_addr(rd_addr), .prog_word(pw), .cfg_word(cw));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [87:0] e, input logic [87:0] s);
        num_checks++;
        if (s !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        wr_s  <= 1'b1;
        rd_s  <= 1'b0;
        addr  <= a;
        wdata <= v;
    endtask
    // Note taken at issue; the monitor pairs it with the answer
    task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
        @(posedge clk);
        wr_s <= 1'b0;
        rd_s <= 1'b1;
        addr <= a;
        rd_q.push_back({e & m, m});
    endtask
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge clk);
            wr_s <= 1'b0;
            rd_s <= 1'b0;
        end
    endtask
    task automatic set_ptr(input logic [21:0] v);
        wr(tpf_pkg::ADDR_PTR_LOW, v[7:0]);
        wr(tpf_pkg::ADDR_PTR_HIGH, v[15:8]);
        wr(tpf_pkg::ADDR_PTR_UPPER, {2'h0, v[21:16]});
    endtask
    task automatic start(input logic [7:0] c);
        wr(tpf_pkg::ADDR_CONTROL, c & 8'hfd);
        wr(tpf_pkg::ADDR_KEY, tpf_pkg::KEY_FIRST);
        wr(tpf_pkg::ADDR_KEY, tpf_pkg::KEY_SECOND);
        wr(tpf_pkg::ADDR_CONTROL, c);
        idle(1);
    endtask
    function automatic logic [7:0] mem_byte(input logic [21:0] a);
        logic [15:0] w;
        w = a[21] ? {a[8:1] ^ 8'hc5, ~a[8:1]} : {a[8:1] ^ 8'h3c, a[16:9]};
        return a[0] ? w[15:8] : w[7:0];
    endfunction
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Read data stands only in the cycle after the strobe
    always @(negedge clk) begin
        if (rd_flag === 1'b1) begin
            re = rd_q.pop_front();
            check("read data", 88'(re[15:8]), 88'(rdata & re[7:0]));
        end
        rd_flag = rd_s;
        if ((prog | ers) === 1'b1) begin
            ee = (ev_q.size() > 0) ? ev_q.pop_front() : 88'h0;
            check("array op", ee, {prog, ers, blk, ers ? 64'h0 : pdata});
        end
    end
    initial begin
        #50000;
        err_total++;
        end_of_test();
    end
    initial begin
        arst_n = 1'b0;
        addr = 4'h0;
        wdata = 8'h00;
        wr_s = 1'b0;
        rd_s = 1'b0;
        rd_flag = 1'b0;
        err_total = 0;
        num_checks = 0;
        void'($urandom(11758));
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        rd(tpf_pkg::ADDR_CONTROL, tpf_pkg::CTL_RESET, 8'hff);
        rd(4'h9, 8'h00, 8'hff);
        // Every mode, wrap edges first, then random pointers
        for (int i = 0; i < 8; i++) begin
            p = (i < 4) ? BND[i] : 22'($urandom());
            d = (i % 4 == 2) ? 21'h1fffff : 21'(i % 2);
            np = {p[21], p[20:0] + d};
            acc = (i % 4 == 3) ? np : p;
            set_ptr(p);
            wr(tpf_pkg::ADDR_TABLE_OP, 8'(i % 4));
            idle(2);
            rd(tpf_pkg::ADDR_LATCH, mem_byte(acc), 8'hff);
            rd(tpf_pkg::ADDR_PTR_LOW, np[7:0], 8'hff);
            rd(tpf_pkg::ADDR_PTR_HIGH, np[15:8], 8'hff);
            rd(tpf_pkg::ADDR_PTR_UPPER, {2'h0, np[21:16]}, 8'h3f);
        end
        // Holding fill starts mid-block so the index wraps
        p = (22'($urandom()) & 22'h1ffff8) | 22'h3;
        set_ptr(p);
        for (int k = 0; k < 8; k++) begin
            b = 8'($urandom());
            hold[8 * ((k + 3) % 8) +: 8] = b;
            wr(tpf_pkg::ADDR_LATCH, b);
            wr(tpf_pkg::ADDR_TABLE_OP, 8'h05);
        end
        np = {p[21], p[20:0] + 21'h8};
        ev_q.push_back({2'b10, np & 22'h3ffff8, hold});
        start(8'h86);
        idle(3);
        wr(tpf_pkg::ADDR_CONTROL, 8'h00);
        rd(tpf_pkg::ADDR_STATUS, 8'h01, 8'h01);
        idle(LWC);
        rd(tpf_pkg::ADDR_CONTROL, 8'h00, 8'h02);
        p = 22'($urandom()) & 22'h1fffff;
        set_ptr(p);
        ev_q.push_back({2'b01, p & 22'h3fffc0, 64'h0});
        start(8'h96);
        idle(LWC + 2);
        rd(tpf_pkg::ADDR_CONTROL, 8'h00, 8'h12);
        // Broken key, intervening access, no permit, config space
        for (int c = 0; c < 4; c++) begin
            wr(tpf_pkg::ADDR_KEY, tpf_pkg::KEY_FIRST);
            if (c == 1) rd(tpf_pkg::ADDR_PTR_LOW, p[7:0], 8'hff);
            wr(tpf_pkg::ADDR_KEY, (c == 0) ? 8'h12 : tpf_pkg::KEY_SECOND);
            wr(tpf_pkg::ADDR_CONTROL, (c == 2) ? 8'h92 : ((c == 3) ? 8'hd6 : 8'h96));
            idle(2);
            rd(tpf_pkg::ADDR_STATUS, 8'h00, 8'h01);
        end
        // Reset cuts an erase short
        ev_q.push_back({2'b01, p & 22'h3fffc0, 64'h0});
        start(8'h96);
        idle(4);
        arst_n <= 1'b0;
        idle(2);
        arst_n <= 1'b1;
        rd(tpf_pkg::ADDR_CONTROL, 8'h88, 8'hc8);
        idle(3);
        check("pending notes", 88'h0, 88'(rd_q.size() + ev_q.size()));
        end_of_test();
    end
endmodule
